// ==== rtl/meas_setup_cfg.svh ====
// register offsets, field positions, reset values and timing counts for the setup register
// assumes inclusion by bare name from the design files
`ifndef MEAS_SETUP_CFG_SVH
`define MEAS_SETUP_CFG_SVH

`define SETUP_INDEX        16'hE618
`define SETUP_BYTE_ADDR    18'h39860
`define SETUP_RESET        16'h0000
`define SETUP_WMASK        16'h3FF9
`define BIT_INTEG          0
`define BIT_SWAP           3
`define BIT_VZERO          4
`define BIT_IZERO          5
`define BIT_FASTCAP        6
`define BIT_SOFTRST        7
`define FLD_PAIR_A         8
`define FLD_PAIR_B         10
`define FLD_PAIR_C         12
`define SOFTRST_TIME_NS    80
`define CLK_PERIOD_NS      8
`define SOFTRST_CYCLES     ((`SOFTRST_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== rtl/meas_setup_pkg.sv ====
// types shared by the setup register design
// assumes the cfg header carries all numbers
package meas_setup_pkg;
  typedef enum logic [1:0] {
    phase_a,
    phase_b,
    phase_c
  } phase_sel_t;

  typedef enum {
    st_idle,
    st_reset
  } srst_state_t;
endpackage : meas_setup_pkg

// ==== rtl/pair_decode.sv ====
// decodes one voltage pairing field into a phase selection
// assumes a purely combinational use by the setup register
`timescale 1ns/100ps
module pair_decode
  import meas_setup_pkg::*;
#(
  parameter phase_sel_t home = phase_a
) (
  input  wire logic [1:0] code,     // pairing field
  output phase_sel_t      phase     // selected voltage phase
);
  // reserved 11 behaves as 00: fall back to the home phase
  always_comb begin
    unique case (code)
      2'h1:    phase = (home == phase_c) ? phase_a : phase_sel_t'(home + 2'h1);
      2'h2:    phase = (home == phase_a) ? phase_c : phase_sel_t'(home - 2'h1);
      default: phase = home;
    endcase
  end
endmodule : pair_decode

// ==== rtl/soft_reset_timer.sv ====
// stretches a software reset request into a fixed-length pulse
// assumes the request is a one-cycle pulse on ref_clk
`timescale 1ns/100ps
`include "meas_setup_cfg.svh"
module soft_reset_timer
  import meas_setup_pkg::*;
(
  input  wire logic ref_clk,   // device clock
  input  wire logic rst_b,     // synchronous reset, active low
  input  wire logic start,     // request pulse
  output logic      active,    // reset in progress
  output logic      done       // one-cycle end pulse
);
  localparam logic [7:0] last_cnt = 8'(`SOFTRST_CYCLES - 1);
  srst_state_t state_q, state_d;
  logic [7:0]  cnt_q, cnt_d;
  logic        done_d;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    done_d  = 1'b0;
    unique case (state_q)
      st_idle: begin
        if (start) begin
          state_d = st_reset;
          cnt_d   = 8'h00;
        end
      end
      st_reset: begin
        if (cnt_q == last_cnt) begin
          state_d = st_idle;
          done_d  = 1'b1;
        end else begin
          cnt_d = cnt_q + 8'h01;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_q <= st_idle;
      cnt_q   <= 8'h00;
      done    <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      done    <= done_d;
    end
  end

  assign active = (state_q == st_reset);
endmodule : soft_reset_timer

// ==== rtl/measurement_setup_register.sv ====
// measurement setup register behind an Avalon-MM slave, driving datapath controls
// assumes the master holds requests until waitrequest is sampled low
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "meas_setup_cfg.svh"
module measurement_setup_register
  import meas_setup_pkg::*;
(
  input  wire logic        ref_clk,                 // 125 MHz device clock
  input  wire logic        rst_b,                   // synchronous reset, active low
  input  wire logic [17:0] avs_address,             // byte address
  input  wire logic        avs_read,                // read request
  input  wire logic        avs_write,               // write request
  input  wire logic [31:0] avs_writedata,           // write data
  input  wire logic [3:0]  avs_byteenable,          // byte lanes
  output logic [31:0]      avs_readdata,            // read data
  output logic             avs_waitrequest,         // stall
  output logic [1:0]       avs_response,            // 00 ok, 10 slave error
  output logic             integrator_enable,       // integrator on
  output logic             channel_swap,            // swap voltage and current results
  output logic             voltage_adc_force_zero,  // voltage modulators grounded
  output logic             current_adc_force_zero,  // current modulators grounded
  output logic             fast_capture_port_enable,// capture port on
  input  wire logic        fast_capture_clock,      // capture clock from port logic
  input  wire logic        third_pulse_output,      // third pulse from energy logic
  output logic             shared_pin_out,          // shared pin level
  output logic             soft_reset_active,       // software reset in progress
  output phase_sel_t       phase_a_voltage_pairing, // voltage for phase A current
  output phase_sel_t       phase_b_voltage_pairing, // voltage for phase B current
  output phase_sel_t       phase_c_voltage_pairing  // voltage for phase C current
);
  logic [15:0] setup_q, setup_d;
  logic        ack_q, ack_d;
  logic [31:0] rdata_d;
  logic [1:0]  resp_d;
  logic        hit;
  logic        srst_start;
  logic        srst_done;
  logic [15:0] lane_mask;
  logic        req;

  assign req       = avs_read | avs_write;
  assign hit       = (avs_address == `SETUP_BYTE_ADDR);
  assign lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  // one wait cycle: the answer is registered so readdata comes from flops
  assign avs_waitrequest = req & ~ack_q;
  // trigger as a written one lands
  assign srst_start = avs_write & ack_q & hit & avs_byteenable[0]
                      & avs_writedata[`BIT_SOFTRST];

  always_comb begin
    setup_d = setup_q;
    ack_d   = req & ~ack_q;
    rdata_d = avs_readdata;
    resp_d  = avs_response;
    if (req & ~ack_q) begin
      resp_d  = hit ? 2'h0 : 2'h2;
      rdata_d = 32'h0000_0000;
      if (avs_read & hit) begin
        rdata_d = {16'h0000, setup_q};
      end
    end
    // reserved bits never stored; writes land only where waitrequest is low
    if (avs_write & ack_q & hit) begin
      setup_d = (setup_q & ~(lane_mask & `SETUP_WMASK))
                | (avs_writedata[15:0] & lane_mask & `SETUP_WMASK);
    end
    // defaults restored at end of soft reset
    if (srst_done) begin
      setup_d = `SETUP_RESET;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      setup_q      <= `SETUP_RESET;
      ack_q        <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'h0;
    end else begin
      setup_q      <= setup_d;
      ack_q        <= ack_d;
      avs_readdata <= rdata_d;
      avs_response <= resp_d;
    end
  end

  soft_reset_timer u_srst (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .start   (srst_start),
    .active  (soft_reset_active),
    .done    (srst_done)
  );

  assign integrator_enable        = setup_q[`BIT_INTEG];
  assign channel_swap             = setup_q[`BIT_SWAP];
  assign voltage_adc_force_zero   = setup_q[`BIT_VZERO];
  assign current_adc_force_zero   = setup_q[`BIT_IZERO];
  assign fast_capture_port_enable = setup_q[`BIT_FASTCAP];
  assign shared_pin_out = setup_q[`BIT_FASTCAP] ? fast_capture_clock : third_pulse_output;

  pair_decode #(.home(phase_a)) u_pair_a (
    .code  (setup_q[`FLD_PAIR_A +: 2]),
    .phase (phase_a_voltage_pairing)
  );
  pair_decode #(.home(phase_b)) u_pair_b (
    .code  (setup_q[`FLD_PAIR_B +: 2]),
    .phase (phase_b_voltage_pairing)
  );
  pair_decode #(.home(phase_c)) u_pair_c (
    .code  (setup_q[`FLD_PAIR_C +: 2]),
    .phase (phase_c_voltage_pairing)
  );

  property p_srst_start;
    @(posedge ref_clk) disable iff (!rst_b)
      srst_start |=> soft_reset_active;
  endproperty
  a_srst_start: assert property (p_srst_start) else $error("soft reset did not start");

  property p_srst_clear;
    @(posedge ref_clk) disable iff (!rst_b)
      $rose(soft_reset_active) |-> ##[1:20] (setup_q == 16'h0000);
  endproperty
  a_srst_clear: assert property (p_srst_clear) else $error("setup not cleared");

  property p_reserved;
    @(posedge ref_clk) disable iff (!rst_b)
      setup_q[2:1] == 2'h0 && setup_q[15:14] == 2'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

  property p_pin_cap;
    @(posedge ref_clk) disable iff (!rst_b)
      fast_capture_port_enable |-> shared_pin_out == fast_capture_clock;
  endproperty
  a_pin_cap: assert property (p_pin_cap) else $error("pin not capture clock");

  property p_pin_cf;
    @(posedge ref_clk) disable iff (!rst_b)
      !fast_capture_port_enable |-> shared_pin_out == third_pulse_output;
  endproperty
  a_pin_cf: assert property (p_pin_cf) else $error("pin not pulse output");

  property p_pair_rsv;
    @(posedge ref_clk) disable iff (!rst_b)
      setup_q[9:8] == 2'h3 |-> phase_a_voltage_pairing == phase_a;
  endproperty
  a_pair_rsv: assert property (p_pair_rsv) else $error("reserved pairing wrong");

  // phase B code 10 gives A
  property p_pair_b;
    @(posedge ref_clk) disable iff (!rst_b)
      setup_q[11:10] == 2'h2 |-> phase_b_voltage_pairing == phase_a;
  endproperty
  a_pair_b: assert property (p_pair_b) else $error("phase b pairing wrong");

  // phase C code 01 gives A
  property p_pair_c;
    @(posedge ref_clk) disable iff (!rst_b)
      setup_q[13:12] == 2'h1 |-> phase_c_voltage_pairing == phase_a;
  endproperty
  a_pair_c: assert property (p_pair_c) else $error("phase c pairing wrong");

  property p_integ;
    @(posedge ref_clk) disable iff (!rst_b)
      (avs_write && !avs_waitrequest && hit && avs_byteenable[0] && !srst_done)
        |=> integrator_enable == $past(avs_writedata[0]);
  endproperty
  a_integ: assert property (p_integ) else $error("integrator bit not written");

  property p_swap;
    @(posedge ref_clk) disable iff (!rst_b)
      (avs_write && !avs_waitrequest && hit && avs_byteenable[0] && !srst_done)
        |=> channel_swap == $past(avs_writedata[`BIT_SWAP]);
  endproperty
  a_swap: assert property (p_swap) else $error("swap bit not written");

  // voltage force zero follows a written bit
  property p_vzero;
    @(posedge ref_clk) disable iff (!rst_b)
      (avs_write && !avs_waitrequest && hit && avs_byteenable[0] && !srst_done)
        |=> voltage_adc_force_zero == $past(avs_writedata[`BIT_VZERO]);
  endproperty
  a_vzero: assert property (p_vzero) else $error("voltage zero bit not written");

  // current force zero follows a written bit
  property p_izero;
    @(posedge ref_clk) disable iff (!rst_b)
      (avs_write && !avs_waitrequest && hit && avs_byteenable[0] && !srst_done)
        |=> current_adc_force_zero == $past(avs_writedata[`BIT_IZERO]);
  endproperty
  a_izero: assert property (p_izero) else $error("current zero bit not written");

  // capture enable follows a written bit
  property p_fastcap;
    @(posedge ref_clk) disable iff (!rst_b)
      (avs_write && !avs_waitrequest && hit && avs_byteenable[0] && !srst_done)
        |=> fast_capture_port_enable == $past(avs_writedata[`BIT_FASTCAP]);
  endproperty
  a_fastcap: assert property (p_fastcap) else $error("capture enable not written");

  // phase A code 01 gives B
  property p_pair_a1;
    @(posedge ref_clk) disable iff (!rst_b)
      setup_q[9:8] == 2'h1 |-> phase_a_voltage_pairing == phase_b;
  endproperty
  a_pair_a1: assert property (p_pair_a1) else $error("phase a pairing 01 wrong");

  // phase A code 10 gives C
  property p_pair_a2;
    @(posedge ref_clk) disable iff (!rst_b)
      setup_q[9:8] == 2'h2 |-> phase_a_voltage_pairing == phase_c;
  endproperty
  a_pair_a2: assert property (p_pair_a2) else $error("phase a pairing 10 wrong");

  // phase B code 01 gives C
  property p_pair_b1;
    @(posedge ref_clk) disable iff (!rst_b)
      setup_q[11:10] == 2'h1 |-> phase_b_voltage_pairing == phase_c;
  endproperty
  a_pair_b1: assert property (p_pair_b1) else $error("phase b pairing 01 wrong");

  // phase C code 10 gives B
  property p_pair_c2;
    @(posedge ref_clk) disable iff (!rst_b)
      setup_q[13:12] == 2'h2 |-> phase_c_voltage_pairing == phase_b;
  endproperty
  a_pair_c2: assert property (p_pair_c2) else $error("phase c pairing 10 wrong");

  // phase B reserved code acts as 00
  property p_pair_b_rsv;
    @(posedge ref_clk) disable iff (!rst_b)
      setup_q[11:10] == 2'h3 |-> phase_b_voltage_pairing == phase_b;
  endproperty
  a_pair_b_rsv: assert property (p_pair_b_rsv) else $error("phase b reserved wrong");

  // phase C reserved code acts as 00
  property p_pair_c_rsv;
    @(posedge ref_clk) disable iff (!rst_b)
      setup_q[13:12] == 2'h3 |-> phase_c_voltage_pairing == phase_c;
  endproperty
  a_pair_c_rsv: assert property (p_pair_c_rsv) else $error("phase c reserved wrong");

  property p_reset_zero;
    @(posedge ref_clk)
      !rst_b |=> setup_q == `SETUP_RESET && !soft_reset_active;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset did not clear");

  // no written one, no soft reset
  property p_srst_quiet;
    @(posedge ref_clk) disable iff (!rst_b)
      (!soft_reset_active && !(avs_write && hit && avs_writedata[`BIT_SOFTRST]))
        |=> !soft_reset_active;
  endproperty
  a_srst_quiet: assert property (p_srst_quiet) else $error("soft reset started unasked");

  // defaults back once the pulse ends
  property p_srst_end;
    @(posedge ref_clk) disable iff (!rst_b)
      $fell(soft_reset_active) |=> setup_q == `SETUP_RESET;
  endproperty
  a_srst_end: assert property (p_srst_end) else $error("defaults not restored");

  // unmapped access answers zero with an error
  property p_miss;
    @(posedge ref_clk) disable iff (!rst_b)
      (req && !ack_q && !hit) |=> avs_response == 2'h2 && avs_readdata == 32'h0000_0000;
  endproperty
  a_miss: assert property (p_miss) else $error("unmapped access answered wrongly");

  property p_integ_hold;
    @(posedge ref_clk) disable iff (!rst_b)
      (!(avs_write && hit) && !srst_done) |=> $stable(integrator_enable);
  endproperty
  a_integ_hold: assert property (p_integ_hold) else $error("integrator bit moved");
endmodule : measurement_setup_register

// ==== dv/tb_measurement_setup_register.sv ====
// self-checking bench for the setup register: Avalon-MM accesses plus control outputs
// assumes the design's cfg header and package are compiled first
`timescale 1ns/100ps
`include "meas_setup_cfg.svh"
module tb_measurement_setup_register
  import meas_setup_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [17:0] avs_address;
  logic        avs_read, avs_write;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic        avs_waitrequest;
  logic [1:0]  avs_response;
  logic        integrator_enable, channel_swap, voltage_adc_force_zero;
  logic        current_adc_force_zero, fast_capture_port_enable;
  logic        fast_capture_clock, third_pulse_output, shared_pin_out, soft_reset_active;
  phase_sel_t  phase_a_voltage_pairing, phase_b_voltage_pairing, phase_c_voltage_pairing;
  int          fails = 0;
  int          num_checks = 0;
  int          act_cnt = 0;
  logic [1:0]  rs;
  logic [31:0] rd;

  measurement_setup_register DUT (
    .ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .integrator_enable(integrator_enable),
    .channel_swap(channel_swap), .voltage_adc_force_zero(voltage_adc_force_zero),
    .current_adc_force_zero(current_adc_force_zero),
    .fast_capture_port_enable(fast_capture_port_enable),
    .fast_capture_clock(fast_capture_clock), .third_pulse_output(third_pulse_output),
    .shared_pin_out(shared_pin_out), .soft_reset_active(soft_reset_active),
    .phase_a_voltage_pairing(phase_a_voltage_pairing),
    .phase_b_voltage_pairing(phase_b_voltage_pairing),
    .phase_c_voltage_pairing(phase_c_voltage_pairing));

  always #4 ref_clk = ~ref_clk;
  // sampled mid-cycle so the count never races the register update
  always @(negedge ref_clk) if (soft_reset_active === 1'b1) act_cnt++;

  task automatic stop_test;
    if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk32

  task automatic chk_ph(input string nm, input phase_sel_t e, input phase_sel_t g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_ph

  // waitrequest and the answer are read at the rising edge, before the design updates
  task automatic bus(input logic wr, input logic [17:0] a, input logic [31:0] wd,
                     input logic [3:0] be, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    r = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk32("wait_cycles", 32'd2, n);
  endtask : bus

  task automatic wr_reg(input logic [17:0] a, input logic [31:0] wd, input logic [3:0] be);
    bus(1'b1, a, wd, be, rd, rs);
  endtask : wr_reg

  task automatic rd_reg(input logic [17:0] a);
    bus(1'b0, a, 32'h0, 4'hF, rd, rs);
  endtask : rd_reg

  // reserved code 11 falls back to the field's home phase
  function automatic phase_sel_t exp_ph(input int home, input logic [1:0] c);
    return phase_sel_t'((c == 2'h3) ? home : (home + c) % 3);
  endfunction : exp_ph

  task automatic chk_outs(input logic [15:0] v);
    rd_reg(`SETUP_BYTE_ADDR);
    chk32("readback", {16'h0, v}, rd);
    chk32("response", 32'h0, {30'h0, rs});
    chk32("integ", {31'h0, v[`BIT_INTEG]}, {31'h0, integrator_enable});
    chk32("swap", {31'h0, v[`BIT_SWAP]}, {31'h0, channel_swap});
    chk32("vzero", {31'h0, v[`BIT_VZERO]}, {31'h0, voltage_adc_force_zero});
    chk32("izero", {31'h0, v[`BIT_IZERO]}, {31'h0, current_adc_force_zero});
    chk32("fastcap", {31'h0, v[`BIT_FASTCAP]}, {31'h0, fast_capture_port_enable});
    chk_ph("pair_a", exp_ph(0, v[9:8]), phase_a_voltage_pairing);
    chk_ph("pair_b", exp_ph(1, v[11:10]), phase_b_voltage_pairing);
    chk_ph("pair_c", exp_ph(2, v[13:12]), phase_c_voltage_pairing);
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      fast_capture_clock <= k[0];
      third_pulse_output <= !k[0];
      @(negedge ref_clk);
      chk32("pin_mux", {31'h0, v[`BIT_FASTCAP] ~^ k[0]}, {31'h0, shared_pin_out});
    end
  endtask : chk_outs

  initial begin
    avs_address <= 18'h0;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= 32'h0;
    avs_byteenable <= 4'h0;
    fast_capture_clock <= 1'b0;
    third_pulse_output <= 1'b0;
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    chk_outs(16'h0000);
    for (int b = 0; b < 7; b++) begin
      wr_reg(`SETUP_BYTE_ADDR, 32'h1 << b, 4'hF);
      chk_outs((16'h1 << b) & `SETUP_WMASK);
    end
    wr_reg(`SETUP_BYTE_ADDR, 32'h0000_FF79, 4'hF);
    chk_outs(16'h3F79);
    for (int c = 0; c < 4; c++) begin
      wr_reg(`SETUP_BYTE_ADDR, {18'h0, 2'(c + 2), 2'(c + 1), 2'(c), 8'h00}, 4'hF);
      chk_outs({2'h0, 2'(c + 2), 2'(c + 1), 2'(c), 8'h00});
    end
    wr_reg(`SETUP_BYTE_ADDR, 32'h0000_0001, 4'hF);
    wr_reg(`SETUP_BYTE_ADDR, 32'hFFFF_2AFE, 4'h2);
    chk_outs(16'h2A01);
    // unmapped place: write ignored, read zero with slave error
    wr_reg(`SETUP_BYTE_ADDR + 18'h4, 32'h0000_0079, 4'hF);
    rd_reg(`SETUP_BYTE_ADDR + 18'h4);
    chk32("miss_data", 32'h0, rd);
    chk32("miss_resp", 32'h2, {30'h0, rs});
    chk_outs(16'h2A01);
    act_cnt = 0;
    wr_reg(`SETUP_BYTE_ADDR, 32'h0000_00F9, 4'h1);
    repeat (30) @(negedge ref_clk);
    chk32("soft_reset_len", 32'd10, act_cnt);
    chk_outs(16'h0000);
    wr_reg(`SETUP_BYTE_ADDR, 32'h0000_3F79, 4'hF);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    chk_outs(16'h0000);
    stop_test();
  end

  // the whole sequence needs well under 2000 cycles
  initial begin
    #100000;
    fails++;
    stop_test();
  end
endmodule : tb_measurement_setup_register
